// ==== cpu_control_and_register_file_tb.sv ====
// Self-checking bench for the CPU control and register core.
// Assumes cpu_ctl_core as declared, APB slave with zero wait states.
`timescale 1ns/1ns
module cpu_control_and_register_file_tb
    import cpu_ctl_pkg::*;
;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic        clk_sys, rst, pready, pslverr, er;
    apb_req_t    apb;
    core_op_t    op;
    gpr_req_t    gpr_req;
    stk_wr_t     stk_wr;
    region_t     mem_region;
    logic [31:0] prdata, rd;
    logic [7:0]  vec_lo, vec_hi, stack_rdata, psw_out;
    logic [15:0] stack_rd_addr, pc_out, alu_result, gpr_rdata, mem_addr;
    logic        irq_req, irq_low_prio, irq_nmi, irq_grant, sfr_misaligned, special_mode_ok;
    logic [1:0]  mem_width;
    int          n_fail, num_checks;

    cpu_ctl_core dut (.clk_sys(clk_sys), .rst(rst), .apb(apb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .op(op), .vec_lo(vec_lo), .vec_hi(vec_hi),
        .stack_rdata(stack_rdata), .stack_rd_addr(stack_rd_addr), .stk_wr(stk_wr),
        .pc_out(pc_out), .psw_out(psw_out), .alu_result(alu_result), .gpr_req(gpr_req),
        .gpr_rdata(gpr_rdata), .irq_req(irq_req), .irq_low_prio(irq_low_prio),
        .irq_nmi(irq_nmi), .irq_grant(irq_grant), .mem_addr(mem_addr),
        .mem_width(mem_width), .mem_region(mem_region),
        .sfr_misaligned(sfr_misaligned), .special_mode_ok(special_mode_ok));

    // 100 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task chk(input string n, input logic [63:0] e, input logic [63:0] s);
        num_checks++;
        if (s !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    // One APB transfer, held until pready is sampled high
    task apb_xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        apb <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk_sys);
        apb.penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        apb <= '0;
    endtask
    // One core operation for one cycle, then settle
    task run(input op_t c, input logic [15:0] d, input logic [7:0] a, input logic [7:0] b);
        @(posedge clk_sys);
        op <= '{c, 3'h3, d, a, b};
        @(posedge clk_sys);
        op <= '0;
        #1;
    endtask
    task alu(input op_t c, input logic [7:0] a, input logic [7:0] b, input logic [10:0] e);
        run(c, 16'h0001, a, b);
        chk("alu flags", e, {psw_out[Z_BIT], psw_out[AC_BIT], psw_out[CY_BIT], alu_result[7:0]});
    endtask
    task irq(input logic q, input logic l, input logic n, input logic e);
        @(posedge clk_sys);
        irq_req <= q;
        irq_low_prio <= l;
        irq_nmi <= n;
        #1;
        chk("irq_grant", e, irq_grant);
    endtask
    task rg(input logic [15:0] a, input logic [1:0] w, input region_t r, input logic m, input logic s);
        @(posedge clk_sys);
        mem_addr <= a;
        mem_width <= w;
        #1;
        chk("decode", {r, m, s}, {mem_region, sfr_misaligned, special_mode_ok});
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_regs;
        apb_xfer(1'b0, OFS_PSW, 32'h0); chk("psw reset", 32'h02, rd);
        apb_xfer(1'b0, OFS_MM, 32'h0); chk("mm reset", 32'h0, rd);
        apb_xfer(1'b0, OFS_IMS, 32'h0); chk("ims reset", 32'h1, rd);
        apb_xfer(1'b0, 12'h014, 32'h0); chk("unmapped err", 33'h1_0000_0000, {er, rd});
        apb_xfer(1'b1, OFS_SP, 32'hFE00);
        apb_xfer(1'b0, OFS_SP, 32'h0); chk("sp rw", 32'hFE00, rd);
    endtask
    task t_pc;
        run(OP_ADVANCE, 16'h0, 8'h0, 8'h0); chk("pc advance", 16'h1237, pc_out);
        run(OP_BRANCH, 16'h0200, 8'h0, 8'h0); chk("pc branch", 16'h0200, pc_out);
    endtask
    task t_stack;
        apb_xfer(1'b1, OFS_PSW, 32'hC1);
        run(OP_LOAD_SP, 16'hFEF0, 8'h0, 8'h0); chk("sp load", 16'hFEF0, stack_rd_addr);
        run(OP_PUSH_STATUS_INSTRUCTION, 16'h0, 8'h0, 8'h0); chk("push", 41'h1_FEEF_C1_FEEF, {stk_wr, stack_rd_addr});
        @(posedge clk_sys);
        #1; chk("push pulse", 1'b0, stk_wr.we);
        run(OP_POP_STATUS_INSTRUCTION, 16'h0, 8'h0, 8'h0); chk("pop", 24'h82_FEF0, {psw_out, stack_rd_addr});
        run(OP_IRQ_ACCEPT, 16'h0300, 8'h0, 8'h0); chk("accept", 42'h6_01FE_EF82, {psw_out[IE_BIT], pc_out, stk_wr});
        run(OP_RETURN, 16'h0, 8'h0, 8'h0); chk("return", 24'h82_FEF0, {psw_out, stack_rd_addr});
        run(OP_DI, 16'h0, 8'h0, 8'h0); chk("di", 1'b0, psw_out[IE_BIT]);
        run(OP_EI, 16'h0, 8'h0, 8'h0); chk("ei", 1'b1, psw_out[IE_BIT]);
    endtask
    task t_alu;
        alu(OP_ADD, 8'h0F, 8'h01, 11'b010_0001_0000);
        alu(OP_ADD, 8'hFF, 8'h01, 11'b111_0000_0000);
        alu(OP_ADD, 8'h70, 8'h10, 11'b000_1000_0000);
        alu(OP_SUB, 8'h10, 8'h01, 11'b010_0000_1111);
        alu(OP_SUB, 8'h00, 8'h01, 11'b011_1111_1111);
        alu(OP_SUB, 8'h05, 8'h05, 11'b100_0000_0000);
        run(OP_SET_CARRY, 16'h1, 8'h0, 8'h0); chk("carry set", 1'b1, psw_out[CY_BIT]);
        run(OP_SET_CARRY, 16'h0, 8'h0, 8'h0); chk("carry clear", 1'b0, psw_out[CY_BIT]);
    endtask
    task t_bank;
        run(OP_SEL_BANK, 16'h2, 8'h0, 8'h0); chk("bank bits", 2'b10, {psw_out[BANK_SELECT_HIGH_BIT], psw_out[BANK_SELECT_LOW_BIT]});
        @(posedge clk_sys);
        gpr_req <= '{1'b1, 1'b1, 3'h4, 16'hA55A};
        @(posedge clk_sys);
        gpr_req <= '{1'b0, 1'b1, 3'h4, 16'h0};
        #1; chk("pair read", 16'hA55A, gpr_rdata);
        apb_xfer(1'b0, 12'h0B0, 32'h0); chk("even low", 32'h5A, rd);
        apb_xfer(1'b0, 12'h0B4, 32'h0); chk("odd high", 32'hA5, rd);
        @(posedge clk_sys);
        gpr_req <= '{1'b0, 1'b0, 3'h5, 16'h0};
        #1;
        chk("byte read", 16'h00A5, gpr_rdata);
        @(posedge clk_sys);
        gpr_req <= '{1'b0, 1'b1, 3'h4, 16'h0};
        run(OP_SEL_BANK, 16'h0, 8'h0, 8'h0); chk("other bank", 16'h0, gpr_rdata);
    endtask
    task t_irq;
        apb_xfer(1'b1, OFS_PSW, 32'h80);
        irq(1'b1, 1'b1, 1'b0, 1'b0);
        irq(1'b1, 1'b0, 1'b0, 1'b1);
        apb_xfer(1'b1, OFS_PSW, 32'h00);
        irq(1'b1, 1'b0, 1'b0, 1'b0);
        irq(1'b0, 1'b0, 1'b1, 1'b1);
    endtask
    task t_map;
        rg(16'hF400, 2'h1, REG_EXP_RAM, 1'b0, 1'b0);
        rg(16'hF7FF, 2'h1, REG_EXP_RAM, 1'b0, 1'b0);
        rg(16'hFF00, 2'h1, REG_SFR, 1'b0, 1'b1);
        rg(16'hFF11, 2'h2, REG_SFR, 1'b1, 1'b1);
        rg(16'hFF10, 2'h2, REG_SFR, 1'b0, 1'b1);
        rg(16'hF000, 2'h1, REG_UNUSABLE, 1'b0, 1'b0);
        rg(16'hFEE0, 2'h1, REG_GPR, 1'b0, 1'b1);
        rg(16'hFB00, 2'h1, REG_HSRAM, 1'b0, 1'b1);
        rg(16'hEFFF, 2'h1, REG_ROM, 1'b0, 1'b0);
        rg(16'hF800, 2'h1, REG_NONE, 1'b0, 1'b0);
        apb_xfer(1'b1, OFS_MM, 32'h1);
        apb_xfer(1'b1, OFS_IMS, 32'h0);
        rg(16'hF800, 2'h1, REG_EXTERNAL, 1'b0, 1'b0);
        rg(16'hF000, 2'h1, REG_EXTERNAL, 1'b0, 1'b0);
        rg(16'hE000, 2'h1, REG_EXTERNAL, 1'b0, 1'b0);
        rg(16'hDFFF, 2'h1, REG_ROM, 1'b0, 1'b0);
    endtask

    // Main sequence: reset, boot, then scenarios
    initial begin
        rst = 1'b1; apb = '0; op = '0; gpr_req = '0;
        vec_lo = 8'h34; vec_hi = 8'h12; stack_rdata = 8'h82;
        irq_req = 1'b0; irq_low_prio = 1'b0; irq_nmi = 1'b0;
        mem_addr = 16'h0; mem_width = 2'h1; n_fail = 0; num_checks = 0;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1; chk("boot pc", 16'h1234, pc_out);
        chk("boot psw", 8'h02, psw_out);
        t_regs; t_pc; t_stack; t_alu; t_bank; t_irq; t_map;
        end_sim;
    end
    // Watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_fail++;
        end_sim;
    end
endmodule

// ==== cpu_ctl_core.sv ====
// CPU control registers, register banks and data memory decoder.
// Assumes a stack memory that reads combinationally at stack_rd_addr,
// program memory bytes at the reset vector on vec_lo and vec_hi.
//
// Overview of operation
// - Expansion RAM decoded at F400H-F7FFH
// - Peripheral registers in FF00H-FFFFH window
// - External space only when expansion mode enabled
// - F000H-F3FFH unusable at 60 KB, else external when expansion mode enabled
// - Whole 64 KB data; special modes FB00H up
// - Counter advances by length or loads target
// - Reset loads counter from vector 0000H/0001H
// - Vector low byte even, high byte odd
// - Status pushed on accept/push, popped on return
// - Reset sets status word to 02H
// - Enable flag low blocks all but non-maskable
// - Enable cleared by disable/accept, set by enable
// - Zero flag follows zero result
// - Bank field set by select, steers registers
// - Aux carry on carry/borrow at bit 3
// - Priority flag low blocks low-priority requests
// - Carry from add/sub, rotate, bit accumulator
// - Pointer decrements before write, increments after read
// - Four banks of eight bytes at FEE0H-FEFFH
// - Peripheral access 1/8/16 bit, 16 even only
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ns
module cpu_ctl_core
    import cpu_ctl_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire apb_req_t    apb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire core_op_t    op,
    input  wire logic [7:0]  vec_lo,
    input  wire logic [7:0]  vec_hi,
    input  wire logic [7:0]  stack_rdata,
    output logic [15:0]      stack_rd_addr,
    output stk_wr_t          stk_wr,
    output logic [15:0]      pc_out,
    output logic [7:0]       psw_out,
    output logic [15:0]      alu_result,
    input  wire gpr_req_t    gpr_req,
    output logic [15:0]      gpr_rdata,
    input  wire logic        irq_req,
    input  wire logic        irq_low_prio,
    input  wire logic        irq_nmi,
    output logic             irq_grant,
    input  wire logic [15:0] mem_addr,
    input  wire logic [1:0]  mem_width,
    output region_t          mem_region,
    output logic             sfr_misaligned,
    output logic             special_mode_ok
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        mode_t           mode;     // Boot then run
        logic [15:0]     pc;       // Program counter
        logic [7:0]      program_status_word;      // Program status word
        logic [15:0]     sp;       // Stack pointer
        logic [7:0]      mm;       // Expansion mode register
        logic [7:0]      memory_size_switch_reg;      // Memory size register
        logic [31:0][7:0] gpr;     // Four banks of eight bytes
        stk_wr_t         stk;      // Registered stack write
        logic [31:0]     rdata;    // APB read data
        logic            err;      // APB error for this transfer
        logic [15:0]     alu;      // Last arithmetic result
    } state_t;

    state_t state;
    state_t next_state;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Array index of a register in a bank; bank 0 at top slot
    function automatic logic [4:0] gpr_index(input logic [1:0] bank,
                                             input logic [2:0] idx);
        gpr_index = {2'(2'd3 - bank), idx};
    endfunction

    // Bank field of a status word
    function automatic logic [1:0] bank_of(input logic [7:0] program_status_word);
        bank_of = {program_status_word[BANK_SELECT_HIGH_BIT], program_status_word[BANK_SELECT_LOW_BIT]};
    endfunction

    // Sum or difference with carry, aux carry and zero
    function automatic logic [10:0] alu_calc(input logic [7:0] a,
                                             input logic [7:0] b,
                                             input logic sub);
        logic [8:0] full;
        logic       ac;
        full = 9'h000;
        ac   = 1'b0;
        if (sub) begin
            full = {1'b0, a} - {1'b0, b};
            ac   = a[3:0] < b[3:0];
        end else begin
            full = {1'b0, a} + {1'b0, b};
            ac   = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0F;
        end
        alu_calc = {full[8], ac, full[7:0] == 8'h00, full[7:0]};
    endfunction

    // Region of a data address
    function automatic region_t decode(input logic [15:0] a,
                                       input logic [7:0] mm,
                                       input logic [7:0] memory_size_switch_reg);
        logic [15:0] rom_hi;
        rom_hi = memory_size_switch_reg[0] ? ROM_60K_HI : ROM_56K_HI;
        if (a >= SFR_LO) begin
            decode = REG_SFR;
        end else if (a >= GPR_LO) begin
            decode = REG_GPR;
        end else if (a >= HSRAM_LO) begin
            decode = REG_HSRAM;
        end else if (a >= EXP_RAM_LO && a <= EXP_RAM_HI) begin
            decode = REG_EXP_RAM;
        end else if (a <= rom_hi) begin
            decode = REG_ROM;
        end else if (memory_size_switch_reg[0] && a >= GAP_LO && a <= GAP_HI) begin
            decode = REG_UNUSABLE;
        end else if (mm[0] && a < HSRAM_LO) begin
            decode = REG_EXTERNAL;
        end else begin
            decode = REG_NONE;
        end
    endfunction

    // ------------------------------------------------------------
    // Combinational views
    // ------------------------------------------------------------
    logic        apb_wr;    // APB write in its access phase
    logic        apb_setup; // APB setup cycle
    logic [10:0] alu_now;   // Arithmetic of this cycle
    logic [4:0]  gpr_base;  // Index of even register of idx's pair in current bank

    assign apb_wr    = apb.psel & apb.penable & apb.pwrite;
    assign apb_setup = apb.psel & ~apb.penable;
    assign alu_now   = alu_calc(op.a, op.b, op.code == OP_SUB);
    assign gpr_base  = gpr_index(bank_of(state.program_status_word),
                                 {gpr_req.idx[2:1], 1'b0});

    // Slave answers in the access phase at once
    assign pready  = apb.psel & apb.penable;
    assign pslverr = pready & state.err;
    assign prdata  = state.rdata;

    // Register outputs
    assign pc_out        = state.pc;
    assign psw_out       = state.program_status_word;
    assign stk_wr        = state.stk;
    assign alu_result    = state.alu;
    assign stack_rd_addr = state.sp;

    // Single byte or pair, even register low byte
    assign gpr_rdata = gpr_req.pair ?
        {state.gpr[gpr_base + 5'd1], state.gpr[gpr_base]} :
        {8'h00, state.gpr[gpr_base | {4'b0000, gpr_req.idx[0]}]};

    // Interrupt acceptance gate
    always_comb begin
        irq_grant = irq_nmi;
        if (state.program_status_word[IE_BIT] && irq_req) begin
            if (state.program_status_word[ISP_BIT] || !irq_low_prio) begin
                irq_grant = 1'b1;
            end
        end
    end

    // Address decoding for the data memory
    always_comb begin
        mem_region      = decode(mem_addr, state.mm, state.memory_size_switch_reg);
        special_mode_ok = mem_addr >= HSRAM_LO;
        sfr_misaligned  = (mem_region == REG_SFR) &&
                          (mem_width == 2'd2) && mem_addr[0];
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_state        = state;
        next_state.stk.we = 1'b0;
        // Core operations once running
        if (state.mode == MODE_BOOT) begin
            next_state.pc   = {vec_hi, vec_lo};
            next_state.mode = MODE_RUN;
        end else begin
            unique case (op.code)
                OP_NONE: begin
                end
                OP_ADVANCE: begin
                    next_state.pc = state.pc + {13'h0000, op.len};
                end
                OP_BRANCH: begin
                    next_state.pc = op.data;
                end
                OP_PUSH_STATUS_INSTRUCTION: begin
                    next_state.sp        = state.sp - 16'h0001;
                    next_state.stk.we    = 1'b1;
                    next_state.stk.addr  = state.sp - 16'h0001;
                    next_state.stk.wdata = state.program_status_word;
                end
                OP_IRQ_ACCEPT: begin
                    next_state.sp        = state.sp - 16'h0001;
                    next_state.stk.we    = 1'b1;
                    next_state.stk.addr  = state.sp - 16'h0001;
                    next_state.stk.wdata = state.program_status_word;
                    next_state.program_status_word[IE_BIT] = 1'b0;
                    next_state.pc        = op.data;
                end
                OP_POP_STATUS_INSTRUCTION, OP_RETURN: begin
                    next_state.program_status_word = stack_rdata;
                    next_state.sp  = state.sp + 16'h0001;
                end
                OP_EI: begin
                    next_state.program_status_word[IE_BIT] = 1'b1;
                end
                OP_DI: begin
                    next_state.program_status_word[IE_BIT] = 1'b0;
                end
                OP_SEL_BANK: begin
                    next_state.program_status_word[BANK_SELECT_HIGH_BIT] = op.data[1];
                    next_state.program_status_word[BANK_SELECT_LOW_BIT] = op.data[0];
                end
                OP_ADD, OP_SUB: begin
                    next_state.program_status_word[CY_BIT] = alu_now[10];
                    next_state.program_status_word[AC_BIT] = alu_now[9];
                    next_state.program_status_word[Z_BIT]  = alu_now[8];
                    next_state.alu         = {8'h00, alu_now[7:0]};
                end
                OP_SET_CARRY: begin
                    // Rotate shift-out or bit accumulator result
                    next_state.program_status_word[CY_BIT] = op.data[0];
                end
                OP_LOAD_SP: begin
                    next_state.sp = op.data;
                end
                default: begin
                end
            endcase
        end
        // Register bank writes in the selected bank
        if (gpr_req.we) begin
            if (gpr_req.pair) begin
                next_state.gpr[gpr_base]        = gpr_req.wdata[7:0];
                next_state.gpr[gpr_base + 5'd1] = gpr_req.wdata[15:8];
            end else begin
                next_state.gpr[gpr_base | {4'b0000, gpr_req.idx[0]}] =
                    gpr_req.wdata[7:0];
            end
        end
        // APB read data captured in the setup cycle
        if (apb_setup) begin
            next_state.rdata = 32'h0000_0000;
            next_state.err   = 1'b0;
            if (apb.paddr[11:7] == OFS_GPR[11:7] && apb.paddr[1:0] == 2'b00) begin
                next_state.rdata = {24'h000000, state.gpr[apb.paddr[6:2]]};
            end else begin
                unique case (apb.paddr)
                    OFS_PC:  next_state.rdata = {16'h0000, state.pc};
                    OFS_PSW: next_state.rdata = {24'h000000, state.program_status_word};
                    OFS_SP:  next_state.rdata = {16'h0000, state.sp};
                    OFS_MM:  next_state.rdata = {24'h000000, state.mm};
                    OFS_IMS: next_state.rdata = {24'h000000, state.memory_size_switch_reg};
                    default: next_state.err = 1'b1;
                endcase
            end
        end
        // APB writes win over core updates of the same register
        if (apb_wr && !state.err) begin
            if (apb.paddr[11:7] == OFS_GPR[11:7]) begin
                next_state.gpr[apb.paddr[6:2]] = apb.pwdata[7:0];
            end else begin
                unique case (apb.paddr)
                    OFS_PC:  next_state.pc  = apb.pwdata[15:0];
                    OFS_PSW: next_state.program_status_word = apb.pwdata[7:0];
                    OFS_SP:  next_state.sp  = apb.pwdata[15:0];
                    OFS_MM:  next_state.mm  = apb.pwdata[7:0];
                    OFS_IMS: next_state.memory_size_switch_reg = apb.pwdata[7:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state      <= '0;
            state.mode <= MODE_BOOT;
            state.program_status_word  <= PSW_RST;
            state.mm   <= MM_RST;
            state.memory_size_switch_reg  <= IMS_RST;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    logic run_op; // Core op that APB does not override
    assign run_op = state.mode == MODE_RUN && !apb_wr;

    psw_reset_a: assert property ($fell(rst) |-> state.program_status_word == PSW_RST)
        else $error("status word not 02H after reset");
    boot_vec_a: assert property (state.mode == MODE_BOOT |=>
        pc_out == {$past(vec_hi), $past(vec_lo)})
        else $error("counter not loaded from vector");
    pc_adv_a: assert property (run_op && op.code == OP_ADVANCE |=>
        pc_out == $past(pc_out) + 16'($past(op.len)))
        else $error("counter did not advance by length");
    sp_push_a: assert property (run_op && op.code == OP_PUSH_STATUS_INSTRUCTION |=>
        stk_wr.we && stk_wr.addr == state.sp &&
        state.sp == $past(state.sp) - 16'h0001 &&
        stk_wr.wdata == $past(psw_out))
        else $error("push did not predecrement");
    sp_pop_a: assert property (run_op && op.code == OP_POP_STATUS_INSTRUCTION |=>
        state.sp == $past(state.sp) + 16'h0001 &&
        psw_out == $past(stack_rdata))
        else $error("pop did not restore status");
    irq_gate_a: assert property (!psw_out[IE_BIT] && !irq_nmi |-> !irq_grant)
        else $error("request granted while disabled");
    low_prio_a: assert property (!psw_out[ISP_BIT] && irq_low_prio && !irq_nmi
        |-> !irq_grant)
        else $error("low priority granted in service");
    ie_clear_a: assert property (run_op && op.code == OP_IRQ_ACCEPT |=>
        !psw_out[IE_BIT] && stk_wr.we)
        else $error("enable not cleared on acceptance");
    zero_flag_a: assert property (run_op && op.code inside {OP_ADD, OP_SUB} |=>
        psw_out[Z_BIT] == (alu_result == 16'h0000))
        else $error("zero flag wrong");
    ext_gate_a: assert property (!state.mm[0] |-> mem_region != REG_EXTERNAL)
        else $error("external space without expansion mode");
    sfr_align_a: assert property (mem_region == REG_SFR && mem_width == 2'd2
        && mem_addr[0] |-> sfr_misaligned)
        else $error("odd 16-bit peripheral access missed");
    // Bank field follows the select operation
    bank_sel_a: assert property (run_op && op.code == OP_SEL_BANK |=>
        bank_of(psw_out) == $past(op.data[1:0]))
        else $error("bank field not taken from select");
    // Carry loaded from rotate or bit accumulator result
    set_carry_a: assert property (run_op && op.code == OP_SET_CARRY |=>
        psw_out[CY_BIT] == $past(op.data[0]))
        else $error("carry not loaded");

    push_c: cover property (run_op && op.code == OP_PUSH_STATUS_INSTRUCTION ##1 op.code == OP_POP_STATUS_INSTRUCTION);
    accept_c: cover property (irq_grant && run_op && op.code == OP_IRQ_ACCEPT);
    bank_c: cover property (run_op && op.code == OP_SEL_BANK ##1 gpr_req.we);
    sfr_c: cover property (mem_region == REG_SFR && sfr_misaligned);
endmodule

// ==== cpu_ctl_pkg.sv ====
// Package for the CPU control and general register core.
// Assumes one clock and an APB master in the surrounding system.
package cpu_ctl_pkg;
    // ------------------------------------------------------------
    // Data memory map
    // ------------------------------------------------------------
    localparam logic [15:0] EXP_RAM_LO = 16'hF400;  // Expansion RAM
    localparam logic [15:0] EXP_RAM_HI = 16'hF7FF;
    localparam logic [15:0] GAP_LO     = 16'hF000;  // Unusable gap above 60 KB store
    localparam logic [15:0] GAP_HI     = 16'hF3FF;
    localparam logic [15:0] HSRAM_LO   = 16'hFB00;  // High-speed RAM
    localparam logic [15:0] HSRAM_HI   = 16'hFEFF;
    localparam logic [15:0] GPR_LO     = 16'hFEE0;  // Register banks
    localparam logic [15:0] SFR_LO     = 16'hFF00;  // Peripheral window
    localparam logic [15:0] ROM_60K_HI = 16'hEFFF;  // Store limit, 60 KB
    localparam logic [15:0] ROM_56K_HI = 16'hDFFF;  // Store limit, 56 KB
    localparam logic [15:0] VEC_ADDR   = 16'h0000;  // Reset vector low
    // ------------------------------------------------------------
    // Status word layout and reset value
    // ------------------------------------------------------------
    localparam int         IE_BIT   = 7;
    localparam int         Z_BIT    = 6;
    localparam int         BANK_SELECT_HIGH_BIT = 5;
    localparam int         AC_BIT   = 4;
    localparam int         BANK_SELECT_LOW_BIT = 3;
    localparam int         ISP_BIT  = 1;
    localparam int         CY_BIT   = 0;
    localparam logic [7:0] PSW_RST  = 8'h02;
    // ------------------------------------------------------------
    // APB register offsets and reset values
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_PC   = 12'h000;
    localparam logic [11:0] OFS_PSW  = 12'h004;
    localparam logic [11:0] OFS_SP   = 12'h008;
    localparam logic [11:0] OFS_MM   = 12'h00C;  // Bit 0: external on
    localparam logic [11:0] OFS_IMS  = 12'h010;  // Bit 0: store is 60 KB
    localparam logic [11:0] OFS_GPR  = 12'h080;  // 32 words, one byte each
    localparam logic [7:0]  MM_RST   = 8'h00;
    localparam logic [7:0]  IMS_RST  = 8'h01;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NONE, OP_ADVANCE, OP_BRANCH, OP_PUSH_STATUS_INSTRUCTION, OP_POP_STATUS_INSTRUCTION,
        OP_IRQ_ACCEPT, OP_RETURN, OP_EI, OP_DI, OP_SEL_BANK,
        OP_ADD, OP_SUB, OP_SET_CARRY, OP_LOAD_SP
    } op_t;
    typedef enum logic [2:0] {
        REG_ROM, REG_EXP_RAM, REG_UNUSABLE, REG_EXTERNAL,
        REG_HSRAM, REG_GPR, REG_SFR, REG_NONE
    } region_t;
    typedef enum logic {MODE_BOOT, MODE_RUN} mode_t;
    typedef struct packed {
        op_t         code;   // Operation this cycle
        logic [2:0]  len;    // Instruction byte length
        logic [15:0] data;   // Branch target, vector, bank, bit
        logic [7:0]  a;      // Arithmetic operand a
        logic [7:0]  b;      // Arithmetic operand b
    } core_op_t;
    typedef struct packed {
        logic        we;     // Write strobe
        logic        pair;   // 16-bit pair access
        logic [2:0]  idx;    // Register index, pair uses idx[2:1]
        logic [15:0] wdata;  // Write data
    } gpr_req_t;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;
    typedef struct packed {
        logic        we;     // One-cycle stack write strobe
        logic [15:0] addr;   // Stack write address
        logic [7:0]  wdata;  // Byte saved
    } stk_wr_t;
endpackage
